//--- eeio_top.sv
/*
  I/O register block for byte access to the on-chip nonvolatile data memory: address,
  data and control registers, armed program enable, core stall, ready interrupt and
  three scratch registers.
  Assumes the core presents one access per cycle and honours stall_o before the next.
*/
`timescale 1ns/10ps
module eeio_top
  import eeio_pkg::*;
#(
  parameter int NVM_BYTES     = 512,
  parameter int ADDR_W        = 9,
  parameter int ATOMIC_LEN    = ATOMIC_CYCLES,
  parameter int SPLIT_LEN     = SPLIT_CYCLES,
  parameter int CNT_W         = 20
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       osc_tick_i,
  input  wire logic       io_space_i,
  input  wire logic [7:0] addr_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [1:0] bit_op_i,
  input  wire logic [2:0] bit_sel_i,
  input  wire logic       gie_i,
  output logic [7:0]      rdata_o,
  output logic            bit_set_o,
  output logic            stall_o,
  output logic            irq_o
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Folds both address forms onto one I/O index
  function automatic logic [6:0] io_index(input logic io_form, input logic [7:0] a);
    logic [7:0] off;
    off = a - DATA_OFFSET;
    if (io_form) begin
      io_index = {(a <= {2'b00, IO_LAST}), a[5:0]};
    end else begin
      io_index = {(a >= DATA_OFFSET) && (a <= DATA_LAST), off[5:0]};
    end
  endfunction

  logic [6:0]  idx_full;
  logic        idx_ok;
  logic [5:0]  idx;
  logic        bit_ok;
  logic        bit_wr;
  logic        do_wr;
  logic        do_rd;
  logic [7:0]  lanes;
  logic [7:0]  bit_mask;
  logic [7:0]  wval;

  assign idx_full = io_index(io_space_i, addr_i);
  assign idx_ok   = idx_full[6];
  assign idx      = idx_full[5:0];
  // Bit instructions are only legal in the lower half of the port range
  assign bit_ok   = io_space_i && idx_ok && (idx <= IO_BIT_LAST);
  assign bit_wr   = bit_ok && ((bit_op_i == EEIO_BIT_SET) || (bit_op_i == EEIO_BIT_CLEAR));
  assign bit_mask = 8'h01 << bit_sel_i;
  assign do_wr    = ce_i && idx_ok && (wr_i || bit_wr);
  assign do_rd    = ce_i && idx_ok && (rd_i || (bit_ok && (bit_op_i == EEIO_BIT_TEST)));
  // A bit instruction touches only its own lane, so flags elsewhere keep their value
  assign lanes    = bit_wr ? bit_mask : ALL_LANES;
  assign wval     = bit_wr ? ((bit_op_i == EEIO_BIT_SET) ? bit_mask : 8'h00) : wdata_i;

  function automatic logic hit(input logic [5:0] i, input logic [5:0] ofs);
    hit = (i == ofs);
  endfunction

  logic wr_scr0;
  logic wr_scr1;
  logic wr_scr2;
  logic wr_ctl;
  logic wr_dat;
  logic wr_alo;
  logic wr_ahi;

  assign wr_scr0 = do_wr && hit(idx, OFS_SCRATCH0);
  assign wr_scr1 = do_wr && hit(idx, OFS_SCRATCH1);
  assign wr_scr2 = do_wr && hit(idx, OFS_SCRATCH2);
  assign wr_ctl  = do_wr && hit(idx, OFS_CONTROL);
  assign wr_dat  = do_wr && hit(idx, OFS_DATA);
  assign wr_alo  = do_wr && hit(idx, OFS_ADDR_LO);
  assign wr_ahi  = do_wr && hit(idx, OFS_ADDR_HI);

  // ----------------------------------------------------------------
  // Scratch registers
  // ----------------------------------------------------------------
  logic [7:0] scratch [3];
  logic [2:0] scr_wr;

  assign scr_wr = {wr_scr2, wr_scr1, wr_scr0};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_scr
      always_ff @(posedge mclk_i) begin
        if (ce_i) begin
          if (rst_i) begin
            scratch[g] <= SCRATCH_RESET;
          end else if (scr_wr[g]) begin
            scratch[g] <= (scratch[g] & ~lanes) | (wval & lanes);
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  logic              busy;
  logic              done;
  logic              prog_enable;
  logic              master_prog_enable;
  logic [2:0]        master_left;
  logic              ready_irq_enable;
  eeio_mode_t        prog_mode_field;
  logic [ADDR_W-1:0] nvm_address;
  logic [7:0]        nvm_data_buffer;
  logic [7:0]        array_rdata;
  logic [2:0]        stall_left;

  logic set_master;
  logic set_prog;
  logic set_read;
  logic start;
  logic rd_go;
  logic mode_we;

  // Only a one in the written lane arms anything; zeros are dropped
  assign set_master = wr_ctl && lanes[BIT_MASTER_EN] && wval[BIT_MASTER_EN];
  assign set_prog   = wr_ctl && lanes[BIT_PROG_EN] && wval[BIT_PROG_EN];
  assign set_read   = wr_ctl && lanes[BIT_READ_STROBE] && wval[BIT_READ_STROBE];
  // Enable must meet an armed master bit from an earlier write
  assign start      = set_prog && master_prog_enable && !prog_enable && !busy
                      && (prog_mode_field != EEIO_MODE_RESERVED);
  assign rd_go      = set_read && !prog_enable && !busy;
  assign mode_we    = wr_ctl && !prog_enable && !start;

  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      if (rst_i) begin
        master_prog_enable <= 1'b0;
        master_left        <= 3'h0;
      end else if (set_master) begin
        master_prog_enable <= 1'b1;
        master_left        <= MASTER_WINDOW;
      end else if (master_left != 3'h0) begin
        master_left        <= master_left - 3'h1;
        master_prog_enable <= (master_left != 3'h1);
      end
    end
  end

  // Program enable and mode survive a reset taken while the array is busy
  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      if (rst_i && !prog_enable) begin
        prog_mode_field <= EEIO_MODE_ATOMIC;
      end else if (mode_we && !rst_i) begin
        prog_mode_field <= eeio_mode_t'({wval[BIT_MODE_HI] & lanes[BIT_MODE_HI]
                           | prog_mode_field[1] & ~lanes[BIT_MODE_HI],
                           wval[BIT_MODE_LO] & lanes[BIT_MODE_LO]
                           | prog_mode_field[0] & ~lanes[BIT_MODE_LO]});
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      if (done) begin
        prog_enable <= 1'b0;
      end else if (rst_i && !busy) begin
        prog_enable <= 1'b0;
      end else if (start && !rst_i) begin
        prog_enable <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      if (rst_i) begin
        ready_irq_enable <= 1'b0;
      end else if (wr_ctl && lanes[BIT_READY_IE]) begin
        ready_irq_enable <= wval[BIT_READY_IE];
      end
    end
  end

  // ----------------------------------------------------------------
  // Address and data
  // ----------------------------------------------------------------
  // Address has no reset value; software must load it first
  always_ff @(posedge mclk_i) begin
    if (ce_i && !prog_enable && !busy) begin
      if (wr_alo) begin
        nvm_address[7:0] <= (nvm_address[7:0] & ~lanes) | (wval & lanes);
      end
      if (wr_ahi && lanes[0]) begin
        nvm_address[ADDR_W-1] <= wval[0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      if (rd_go) begin
        nvm_data_buffer <= array_rdata;
      end else if (wr_dat) begin
        nvm_data_buffer <= (nvm_data_buffer & ~lanes) | (wval & lanes);
      end
    end
  end

  // ----------------------------------------------------------------
  // Programming timer and array
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] prog_len;

  assign prog_len = (prog_mode_field == EEIO_MODE_ATOMIC) ? CNT_W'(ATOMIC_LEN)
                                                          : CNT_W'(SPLIT_LEN);

  // Counts oscillator ticks so the time holds whatever the core clock is
  eeio_prog_timer #(
    .CNT_W    (CNT_W)
  ) u_timer (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .tick_i   (osc_tick_i),
    .load_i   (start),
    .length_i (prog_len),
    .busy_o   (busy),
    .done_o   (done)
  );

  eeio_nvm_array #(
    .BYTES    (NVM_BYTES),
    .ADDR_W   (ADDR_W)
  ) u_array (
    .mclk_i   (mclk_i),
    .ce_i     (ce_i),
    .commit_i (done),
    .mode_i   (prog_mode_field),
    .addr_i   (nvm_address),
    .wdata_i  (nvm_data_buffer),
    .rdata_o  (array_rdata)
  );

  // ----------------------------------------------------------------
  // Core stall and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      if (rst_i) begin
        stall_left <= 3'h0;
      end else if (start) begin
        stall_left <= STALL_PROG;
      end else if (rd_go) begin
        stall_left <= STALL_READ;
      end else if (stall_left != 3'h0) begin
        stall_left <= stall_left - 3'h1;
      end
    end
  end

  assign stall_o = (stall_left != 3'h0);
  // Level request: stays high while the array is idle and both ready_irq_enable and gie_i are set
  assign irq_o   = ready_irq_enable && gie_i && !prog_enable && !busy;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] ctl_view;
  logic [7:0] addr_hi_view;
  logic [7:0] addr_lo_view;
  logic [7:0] next_rdata;

  assign ctl_view     = {2'b00, prog_mode_field, ready_irq_enable, master_prog_enable,
                         prog_enable, 1'b0};
  assign addr_hi_view = {7'h00, nvm_address[ADDR_W-1] & (ADDR_W > 8)};
  assign addr_lo_view = 8'(nvm_address);

  always_comb begin
    next_rdata = 8'h00;
    unique case (idx)
      OFS_SCRATCH0: next_rdata = scratch[0];
      OFS_SCRATCH1: next_rdata = scratch[1];
      OFS_SCRATCH2: next_rdata = scratch[2];
      OFS_CONTROL:  next_rdata = ctl_view;
      OFS_DATA:     next_rdata = nvm_data_buffer;
      OFS_ADDR_LO:  next_rdata = addr_lo_view;
      OFS_ADDR_HI:  next_rdata = addr_hi_view;
      default:      next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      if (rst_i) begin
        rdata_o   <= 8'h00;
        bit_set_o <= 1'b0;
      end else if (do_rd) begin
        rdata_o   <= next_rdata;
        bit_set_o <= next_rdata[bit_sel_i];
      end
    end
  end

endmodule

//--- eeio_pkg.sv
/*
  Shared constants for the nonvolatile byte access block: I/O offsets, control field
  layout, programming modes and timing figures.
  Assumes a single system clock of 250 MHz.
*/
package eeio_pkg;

  // ----------------------------------------------------------------
  // I/O space layout
  // ----------------------------------------------------------------
  localparam logic [5:0] IO_LAST       = 6'h3F;
  localparam logic [5:0] IO_BIT_LAST   = 6'h1F;
  localparam logic [7:0] DATA_OFFSET   = 8'h20;
  localparam logic [7:0] DATA_LAST     = 8'h5F;
  localparam logic [5:0] OFS_SCRATCH0  = 6'h13;
  localparam logic [5:0] OFS_SCRATCH1  = 6'h14;
  localparam logic [5:0] OFS_SCRATCH2  = 6'h15;
  localparam logic [5:0] OFS_CONTROL   = 6'h1C;
  localparam logic [5:0] OFS_DATA      = 6'h1D;
  localparam logic [5:0] OFS_ADDR_LO   = 6'h1E;
  localparam logic [5:0] OFS_ADDR_HI   = 6'h1F;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int BIT_READ_STROBE = 0;
  localparam int BIT_PROG_EN     = 1;
  localparam int BIT_MASTER_EN   = 2;
  localparam int BIT_READY_IE    = 3;
  localparam int BIT_MODE_LO     = 4;
  localparam int BIT_MODE_HI     = 5;

  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [7:0] ALL_LANES     = 8'hFF;

  typedef enum logic [1:0] {
    EEIO_MODE_ATOMIC   = 2'b00,
    EEIO_MODE_ERASE    = 2'b01,
    EEIO_MODE_WRITE    = 2'b10,
    EEIO_MODE_RESERVED = 2'b11
  } eeio_mode_t;

  typedef enum logic [1:0] {
    EEIO_BIT_NONE  = 2'b00,
    EEIO_BIT_SET   = 2'b01,
    EEIO_BIT_CLEAR = 2'b10,
    EEIO_BIT_TEST  = 2'b11
  } eeio_bitop_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 4000;
  localparam longint ATOMIC_NS    = 3400000;
  localparam longint SPLIT_NS     = 1800000;
  localparam int ATOMIC_CYCLES    = int'((ATOMIC_NS * 1000) / CLK_PERIOD_PS);
  localparam int SPLIT_CYCLES     = int'((SPLIT_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [2:0] MASTER_WINDOW = 3'h4;
  localparam logic [2:0] STALL_PROG    = 3'h2;
  localparam logic [2:0] STALL_READ    = 3'h4;
  localparam logic [7:0] ERASED_BYTE   = 8'hFF;

endpackage

//--- eeio_prog_timer.sv
/*
  Programming duration counter. Counts oscillator ticks down from a loaded length and
  pulses done at the end.
  Assumes tick comes from logic on the same clock; reset does not stop a running count.
*/
`timescale 1ns/10ps
module eeio_prog_timer
  import eeio_pkg::*;
#(
  parameter int CNT_W = 20
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             tick_i,
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] length_i,
  output logic                  busy_o,
  output logic                  done_o
);

  logic [CNT_W-1:0] remain;
  logic             last;

  assign busy_o = (remain != '0);
  assign last   = tick_i && (remain == CNT_W'(1));
  assign done_o = ce_i && last;

  // A reset in mid operation lets the count run out; while idle, reset clears the
  // counter, which also settles an unknown power-up value before anything reads busy
  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      if (busy_o) begin
        if (tick_i) begin
          remain <= remain - CNT_W'(1);
        end
      end else if (rst_i) begin
        remain <= '0;
      end else if (load_i) begin
        remain <= length_i;
      end
    end
  end

endmodule

//--- eeio_nvm_array.sv
/*
  Byte store standing in for the nonvolatile array. Reads are combinational; erase and
  write take effect when the programming time ends.
  Assumes the caller holds address and data stable until commit.
*/
`timescale 1ns/10ps
module eeio_nvm_array
  import eeio_pkg::*;
#(
  parameter int BYTES  = 512,
  parameter int ADDR_W = 9
) (
  input  wire logic              mclk_i,
  input  wire logic              ce_i,
  input  wire logic              commit_i,
  input  wire eeio_mode_t        mode_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  output logic [7:0]             rdata_o
);

  logic [7:0] cells [BYTES];
  logic [7:0] next_cell;

  assign rdata_o = cells[addr_i];

  // Write-only programs zeros into an erased byte; unerased bits stay as they were
  always_comb begin
    unique case (mode_i)
      EEIO_MODE_ATOMIC: next_cell = wdata_i;
      EEIO_MODE_ERASE:  next_cell = ERASED_BYTE;
      EEIO_MODE_WRITE:  next_cell = cells[addr_i] & wdata_i;
      default:          next_cell = cells[addr_i];
    endcase
  end

  // Contents survive reset
  always_ff @(posedge mclk_i) begin
    if (ce_i && commit_i) begin
      cells[addr_i] <= next_cell;
    end
  end

endmodule

//--- eeio_checker.sv
/*
  Port-level checker for the nonvolatile byte access block: control read-back,
  stall lengths, ready interrupt gating and unmapped reads.
  Assumes it is bound to eeio_top and sees only its ports.
*/
`timescale 1ns/10ps
module eeio_checker
  import eeio_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  input wire logic       osc_tick_i,
  input wire logic       io_space_i,
  input wire logic [7:0] addr_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [1:0] bit_op_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic       gie_i,
  input wire logic [7:0] rdata_o,
  input wire logic       bit_set_o,
  input wire logic       stall_o,
  input wire logic       irq_o
);
  // ----------------------------------------------------------------
  // Access decode, data-space form folded back to I/O form
  // ----------------------------------------------------------------
  logic [7:0] io_addr;
  logic       rd_ctl;
  logic       rd_ahi;
  logic       rd_unm;
  logic       wr_ctl;
  assign io_addr = io_space_i ? addr_i : addr_i - DATA_OFFSET;
  assign rd_ctl  = ce_i && rd_i && io_addr == {2'b00, OFS_CONTROL};
  assign rd_ahi  = ce_i && rd_i && io_addr == {2'b00, OFS_ADDR_HI};
  assign rd_unm  = ce_i && rd_i && io_addr >= 8'h20 && io_addr <= 8'h3F;
  assign wr_ctl  = ce_i && wr_i && io_addr == {2'b00, OFS_CONTROL};

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_CTL_RSVD: assert property ($past(rd_ctl) |-> rdata_o[7:6] == 2'b00)
    else $error("control bits 7:6 read nonzero");
  AST_AHI_RSVD: assert property ($past(rd_ahi) |-> rdata_o[7:1] == 7'h00)
    else $error("address high bits 7:1 read nonzero");
  AST_UNMAPPED: assert property ($past(rd_unm) |-> rdata_o == 8'h00)
    else $error("unmapped I/O address read nonzero");
  AST_IRQ_GATE: assert property (irq_o |-> gie_i)
    else $error("ready interrupt without global enable");
  AST_STALL_CAUSE: assert property ($rose(stall_o) |-> $past(wr_ctl))
    else $error("stall without a control write");
  AST_READ_STALL: assert property (
    $rose(stall_o) && $past(wdata_i[BIT_READ_STROBE]) |-> stall_o[*4] ##1 !stall_o)
    else $error("read stall not four cycles");
  AST_PROG_STALL: assert property (
    $rose(stall_o) && !$past(wdata_i[BIT_READ_STROBE]) |-> stall_o[*2] ##1 !stall_o)
    else $error("program stall not two cycles");
  AST_BUSY_NOT_READY: assert property (
    $rose(stall_o) && !$past(wdata_i[BIT_READ_STROBE]) |-> !irq_o [*2])
    else $error("ready interrupt while programming");
endmodule

//--- eeio_core_model.sv
/*
  Processor core model issuing one I/O instruction at a time.
  Assumes the block answers reads one cycle after the taking edge.
*/
`timescale 1ns/10ps
module eeio_core_model (
  input  wire logic       mclk_i,
  input  wire logic       stall_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       bit_set_i,
  output logic            io_space_o,
  output logic [7:0]      addr_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic [7:0]      wdata_o,
  output logic [1:0]      bit_op_o,
  output logic [2:0]      bit_sel_o
);
  logic [7:0] got;
  logic       got_bit;
  int         hung;

  initial begin
    {io_space_o, addr_o, wr_o, rd_o, wdata_o, bit_op_o, bit_sel_o} = '0;
    hung = 0;
  end

  // ----------------------------------------------------------------
  // One instruction; the next waits out any stall like a halted core
  // ----------------------------------------------------------------
  task automatic access(input logic io, input logic [7:0] a, input logic [7:0] d,
                        input logic w, input logic r, input logic [1:0] op,
                        input logic [2:0] s);
    int n;
    @(posedge mclk_i);
    io_space_o <= io;
    addr_o     <= a;
    wdata_o    <= d;
    wr_o       <= w;
    rd_o       <= r;
    bit_op_o   <= op;
    bit_sel_o  <= s;
    @(posedge mclk_i);
    // Released address and data lines show the inverse so stale values cannot pass
    addr_o     <= ~a;
    wdata_o    <= ~d;
    wr_o       <= 1'b0;
    rd_o       <= 1'b0;
    bit_op_o   <= 2'b00;
    #1;
    n = 0;
    while (stall_i === 1'b1 && n < 16) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (n == 16) begin
      hung++;
      eeio_top_tb.finish_test();
    end
    @(posedge mclk_i);
    #1;
    got     = rdata_i;
    got_bit = bit_set_i;
  endtask
endmodule

//--- eeio_top_tb.sv
/*
  Self-checking bench for eeio_top with a core model and a byte-store reference.
  Assumes shortened programming lengths and a tick every other clock.
*/
`timescale 1ns/10ps
module eeio_top_tb
  import eeio_pkg::*;
;
  localparam int         ATOM = 40;
  localparam int         SPLT = 20;
  localparam logic [7:0] CTL  = {2'b00, OFS_CONTROL};
  localparam logic [7:0] DAT  = {2'b00, OFS_DATA};
  localparam logic [7:0] ALO  = {2'b00, OFS_ADDR_LO};
  localparam logic [7:0] AHI  = {2'b00, OFS_ADDR_HI};
  localparam logic [7:0] SCR  = {2'b00, OFS_SCRATCH0};

  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic osc_tick_i = 1'b0;
  logic gie_i = 1'b0;
  logic io_space_i, wr_i, rd_i, bit_set_o, stall_o, irq_o;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic [1:0] bit_op_i;
  logic [2:0] bit_sel_i;
  int n_fail = 0;
  int check_count = 0;
  int run_cnt = 0;
  int last_run = 0;
  int seed, i, m, ex;
  logic [7:0] v, d, a_lo;
  logic       a_hi;
  logic [2:0] s;
  logic [7:0] mem [int];

  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) osc_tick_i <= ~osc_tick_i;
  // Length of the latest not-ready stretch seen on the interrupt line
  always @(posedge mclk_i) begin
    if (irq_o === 1'b1) begin
      if (run_cnt > 0) last_run <= run_cnt;
      run_cnt <= 0;
    end else begin
      run_cnt <= run_cnt + 1;
    end
  end

  eeio_top #(.ATOMIC_LEN(ATOM), .SPLIT_LEN(SPLT)) dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .osc_tick_i(osc_tick_i),
    .io_space_i(io_space_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .wdata_i(wdata_i), .bit_op_i(bit_op_i), .bit_sel_i(bit_sel_i), .gie_i(gie_i),
    .rdata_o(rdata_o), .bit_set_o(bit_set_o), .stall_o(stall_o), .irq_o(irq_o));

  eeio_core_model core_u (
    .mclk_i(mclk_i), .stall_i(stall_o), .rdata_i(rdata_o), .bit_set_i(bit_set_o),
    .io_space_o(io_space_i), .addr_o(addr_i), .wr_o(wr_i), .rd_o(rd_i),
    .wdata_o(wdata_i), .bit_op_o(bit_op_i), .bit_sel_o(bit_sel_i));

  // ----------------------------------------------------------------
  // Bus and result helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    n_fail = n_fail + core_u.hung;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dd);
    core_u.access(1'b1, a, dd, 1'b1, 1'b0, EEIO_BIT_NONE, 3'h0);
  endtask

  task automatic rd(input logic [7:0] a);
    core_u.access(1'b1, a, 8'h00, 1'b0, 1'b1, EEIO_BIT_NONE, 3'h0);
  endtask

  // Wait until program enable reads zero before any read strobe
  task automatic poll;
    int n;
    n = 0;
    rd(CTL);
    while (core_u.got[BIT_PROG_EN] !== 1'b0 && n < 200) begin
      rd(CTL);
      n++;
    end
    if (n == 200) begin
      n_fail++;
      finish_test();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h69243977;
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 3; i++) begin
      rd(SCR + 8'(i));
      check("scratch_reset", core_u.got, SCRATCH_RESET);
    end
    rd(CTL);
    check("control_reset", core_u.got, 8'h00);
    rd(8'h3A);
    check("unmapped", core_u.got, 8'h00);
    for (i = 0; i < 3; i++) begin
      v = 8'($random(seed));
      wr(SCR + 8'(i), v);
      core_u.access(1'b0, SCR + 8'(i) + DATA_OFFSET, 8'h00, 1'b0, 1'b1, EEIO_BIT_NONE, 3'h0);
      check("scratch_data_space", core_u.got, v);
    end
    v = 8'($random(seed));
    s = 3'($random(seed));
    wr(SCR + 8'h01, v);
    core_u.access(1'b1, SCR + 8'h01, 8'h00, 1'b0, 1'b0, EEIO_BIT_SET, s);
    core_u.access(1'b1, SCR + 8'h01, 8'h00, 1'b0, 1'b0, EEIO_BIT_CLEAR, s ^ 3'h1);
    core_u.access(1'b0, SCR + 8'h21, 8'h00, 1'b0, 1'b0, EEIO_BIT_CLEAR, s);
    core_u.access(1'b1, SCR + 8'h01, 8'h00, 1'b0, 1'b0, EEIO_BIT_TEST, s);
    check("bit_test", {7'h00, core_u.got_bit}, 8'h01);
    rd(SCR + 8'h01);
    check("bit_ops", core_u.got, (v | (8'h01 << s)) & ~(8'h01 << (s ^ 3'h1)));
    // Armed program enable
    wr(CTL, 8'h06);
    rd(CTL);
    check("same_write_start", {7'h00, core_u.got[BIT_PROG_EN]}, 8'h00);
    wr(CTL, 8'h04);
    rd(CTL);
    check("master_set", {7'h00, core_u.got[BIT_MASTER_EN]}, 8'h01);
    rd(CTL);
    check("master_cleared", {7'h00, core_u.got[BIT_MASTER_EN]}, 8'h00);
    wr(CTL, 8'h04);
    repeat (3) @(posedge mclk_i);
    wr(CTL, 8'h02);
    rd(CTL);
    check("late_start", {7'h00, core_u.got[BIT_PROG_EN]}, 8'h00);
    wr(CTL, 8'h34);
    wr(CTL, 8'h32);
    rd(CTL);
    check("reserved_mode", {7'h00, core_u.got[BIT_PROG_EN]}, 8'h00);
    // Atomic, erase-only and write-only on one random address
    gie_i <= 1'b1;
    {a_hi, a_lo} = 9'($random(seed));
    wr(AHI, {7'h00, a_hi});
    wr(ALO, a_lo);
    rd(AHI);
    check("address_high", core_u.got, {7'h00, a_hi});
    for (m = 0; m < 3; m++) begin
      d = 8'($random(seed));
      wr(CTL, {2'b00, m[1:0], 4'h8});
      wr(DAT, d);
      wr(CTL, {2'b00, m[1:0], 4'hC});
      wr(CTL, {2'b00, m[1:0], 4'hA});
      wr(ALO, ~a_lo);
      wr(CTL, 8'h38);
      wr(CTL, 8'h39);
      rd(DAT);
      check("strobe_ignored", core_u.got, d);
      poll();
      ex = (m == 0) ? 2 * ATOM : 2 * SPLT;
      check("busy_length", {7'h00, last_run >= ex - 3 && last_run <= ex + 3}, 8'h01);
      mem[{a_hi, a_lo}] = (m == 0) ? d : (m == 1) ? ERASED_BYTE : mem[{a_hi, a_lo}] & d;
      rd(ALO);
      check("address_kept", core_u.got, a_lo);
      rd(CTL);
      check("mode_kept", {6'h00, core_u.got[5:4]}, 8'(m));
      wr(CTL, {2'b00, m[1:0], 4'h9});
      rd(DAT);
      check("stored_byte", core_u.got, mem[{a_hi, a_lo}]);
    end
    check("irq_ready", {7'h00, irq_o}, 8'h01);
    gie_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    check("irq_gated", {7'h00, irq_o}, 8'h00);
    // Reset in mid-programming leaves the erase running
    wr(CTL, 8'h10);
    wr(CTL, 8'h14);
    wr(CTL, 8'h12);
    rst_i <= 1'b1;
    @(posedge mclk_i);
    rst_i <= 1'b0;
    poll();
    check("mode_through_reset", {6'h00, core_u.got[5:4]}, 8'h01);
    wr(CTL, 8'h11);
    rd(DAT);
    check("erase_completed", core_u.got, ERASED_BYTE);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(CTL);
    check("control_idle_reset", core_u.got, 8'h00);
    rd(SCR);
    check("scratch_second_reset", core_u.got, SCRATCH_RESET);
    finish_test();
  end
endmodule

bind eeio_top eeio_checker chk_u (
  .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .osc_tick_i(osc_tick_i),
  .io_space_i(io_space_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
  .wdata_i(wdata_i), .bit_op_i(bit_op_i), .bit_sel_i(bit_sel_i), .gie_i(gie_i),
  .rdata_o(rdata_o), .bit_set_o(bit_set_o), .stall_o(stall_o), .irq_o(irq_o));
